/* File: core/gtm_pkg.sv */
// Package: constants and types of the general-purpose timer and interrupt mitigation block
// Operation
// - Cycle size set: 12.8, 5.12, 51.2 us
// - Cycle size clear: 204.8, 81.92, 819.2 us
// - Transmit timer counts sixteen-cycle-size units
// - Transmit packet count before transmit interrupt
// - Receive timer counts cycle-size units
// - Receive packet count before receive interrupt
// - Continuous-reload bit selects continuous or one-shot
// - Timer value counts iterations of coarse length
// - Reads return live counts, not written values
// - Loaded timer counts down, expiry sets status
// - Continuous reloads last written value; one-shot stops
// - Tick period follows selected network port
// - Timer frozen while in snooze
package gtm_pkg;
    // Core clock
    localparam real CLK_PERIOD_NS = 5.0;
    // Cycle sizes with the cycle-size bit set
    localparam real CYC_TP_FINE_US = 12.8;
    localparam real CYC_SYM_FINE_US = 5.12;
    localparam real CYC_MII10_FINE_US = 51.2;
    // Cycle sizes with the bit clear, also the timer iteration length
    localparam real CYC_TP_COARSE_US = 204.8;
    localparam real CYC_SYM_COARSE_US = 81.92;
    localparam real CYC_MII10_COARSE_US = 819.2;
    localparam int FINE_TP_CYC = int'(CYC_TP_FINE_US * 1000.0 / CLK_PERIOD_NS);
    localparam int FINE_SYM_CYC = int'(CYC_SYM_FINE_US * 1000.0 / CLK_PERIOD_NS);
    localparam int FINE_MII10_CYC = int'(CYC_MII10_FINE_US * 1000.0 / CLK_PERIOD_NS);
    // Coarse unit is a whole number of fine units in every port mode
    localparam int COARSE_PER_FINE = int'(CYC_TP_COARSE_US / CYC_TP_FINE_US);
    localparam int TX_UNIT_MULT = 16;
    localparam int DIV_W = 4;
    localparam int PRE_W = 16;
    // Field widths
    localparam int TMR_W = 4;
    localparam int CNT_W = 3;
    localparam int GP_W = 16;
    localparam int ADDR_W = 8;
    // Byte addresses
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h28;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h38;
    localparam logic [ADDR_W-1:0] ADDR_TMC = 8'h58;
    localparam logic [ADDR_W-1:0] ADDR_PORT = 8'h5c;
    // Control register fields
    localparam int TMC_CS_BIT = 31;
    localparam int TMC_TXT_LO = 27;
    localparam int TMC_TXN_LO = 24;
    localparam int TMC_RXT_LO = 20;
    localparam int TMC_RXN_LO = 17;
    localparam int TMC_CON_BIT = 16;
    localparam int TMC_GP_LO = 0;
    localparam logic [31:0] TMC_RESET = 32'hfffe0000;
    // Status and mask layout
    localparam int STS_TX_BIT = 0;
    localparam int STS_RX_BIT = 6;
    localparam int STS_GP_BIT = 11;
    localparam logic [31:0] STS_RESET = 32'h00000000;
    localparam logic [31:0] MSK_RESET = 32'h00000000;
    // Port modes
    typedef enum logic [1:0] {PORT_TP_AUI, PORT_SYM100, PORT_MII10, PORT_RSVD} gtm_port_t;
endpackage

/* File: core/gtm_chan_if.sv */
// Interface between the block's control logic and one mitigation channel
`timescale 1ns/10ps
`default_nettype none
interface gtm_chan_if #(
    parameter int TW = 4,
    parameter int CW = 3
) ();
    logic en;
    logic tick;
    logic pkt;
    logic load;
    logic [TW-1:0] cfg_timer;
    logic [CW-1:0] cfg_count;
    logic [TW-1:0] tim;
    logic [CW-1:0] cnt;
    logic irq;
    modport chan (input en, tick, pkt, load, cfg_timer, cfg_count, output tim, cnt, irq);
    modport ctl (output en, tick, pkt, load, cfg_timer, cfg_count, input tim, cnt, irq);
endinterface
`default_nettype wire

/* File: core/gtm_mit_chan.sv */
// One interrupt mitigation channel: packet counter and unit timer
`timescale 1ns/10ps
`default_nettype none
module gtm_mit_chan
    import gtm_pkg::*;
#(
    parameter int TW = 4,
    parameter int CW = 3
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Channel link
    gtm_chan_if.chan c
);
    localparam logic [TW-1:0] T_ONE = TW'(1);
    localparam logic [CW-1:0] C_ONE = CW'(1);

    typedef struct packed {
        logic pend;
        logic [TW-1:0] tim;
        logic [CW-1:0] cnt;
        logic irq;
    } gtm_chan_st_t;

    gtm_chan_st_t r_reg;
    gtm_chan_st_t r_next;
    logic fire;

    // Count packets, time units after the first pending packet, fire on either
    always_comb begin
        r_next = r_reg;
        r_next.irq = 1'b0;
        fire = 1'b0;
        if (c.load) begin
            r_next.tim = c.cfg_timer;
            r_next.cnt = c.cfg_count;
            r_next.pend = 1'b0;
        end else begin
            if (c.pkt) begin
                r_next.pend = 1'b1;
                // Both thresholds zero: no mitigation, every packet interrupts
                if (c.cfg_timer == '0 && c.cfg_count == '0) begin
                    fire = 1'b1;
                end else if (c.cfg_count != '0) begin
                    if (r_reg.cnt <= C_ONE) begin
                        fire = 1'b1;
                    end else begin
                        r_next.cnt = r_reg.cnt - C_ONE;
                    end
                end
            end
            // Old pending flag: the packet's own cycle never eats a unit
            if (r_reg.pend && c.tick && c.cfg_timer != '0) begin
                if (r_reg.tim <= T_ONE) begin
                    fire = 1'b1;
                end else begin
                    r_next.tim = r_reg.tim - T_ONE;
                end
            end
            if (fire) begin
                r_next.irq = 1'b1;
                r_next.pend = 1'b0;
                r_next.tim = c.cfg_timer;
                r_next.cnt = c.cfg_count;
            end
        end
    end

    // State register, frozen while the enable is low
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            r_reg <= '{pend: 1'b0, tim: '1, cnt: '1, irq: 1'b0};
        end else if (c.en) begin
            r_reg <= r_next;
        end
    end

    assign c.tim = r_reg.tim;
    assign c.cnt = r_reg.cnt;
    assign c.irq = r_reg.irq;

    sequence s_restart;
        c.irq && c.tim == c.cfg_timer && c.cnt == c.cfg_count && !r_reg.pend;
    endsequence

    a_count_fires: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        c.en && !c.load && c.pkt && c.cfg_count != '0 && r_reg.cnt == C_ONE |=> c.irq)
        else $error("packet count threshold did not raise interrupt");
    a_timer_fires: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        c.en && !c.load && r_reg.pend && c.tick && c.cfg_timer != '0 && r_reg.tim == T_ONE
        |=> s_restart)
        else $error("timer expiry did not raise interrupt and restart");
    a_fire_restart: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        c.en && $rose(c.irq) && $stable(c.cfg_timer) && $stable(c.cfg_count) |-> s_restart)
        else $error("channel did not restart after interrupt");
    a_no_idle_tick: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        c.en && !r_reg.pend && !c.pkt && !c.load |=> !c.irq && c.tim == $past(c.tim))
        else $error("timer moved with no packet pending");
endmodule
`default_nettype wire

/* File: core/gtm_timer_mit.sv */
// Top of the general-purpose timer and interrupt mitigation block with APB slave
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module gtm_timer_mit
    import gtm_pkg::*;
#(
    parameter int FINE_TP = FINE_TP_CYC,
    parameter int FINE_SYM = FINE_SYM_CYC,
    parameter int FINE_MII10 = FINE_MII10_CYC
) (
    // Clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Packet events and power state from the controller
    input wire logic i_rx_pkt,
    input wire logic i_tx_pkt,
    input wire logic i_snooze,
    // Interrupts
    output logic o_irq,
    output logic o_gp_irq,
    output logic o_rx_irq,
    output logic o_tx_irq
);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(COARSE_PER_FINE - 1);
    localparam logic [DIV_W-1:0] TXM_LAST = DIV_W'(TX_UNIT_MULT - 1);
    localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);
    localparam logic [GP_W-1:0] GP_ONE = GP_W'(1);
    localparam logic [PRE_W-1:0] PRE_ONE = PRE_W'(1);

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [DIV_W-1:0] div;
        logic [DIV_W-1:0] txm;
        logic fine;
        logic coarse;
        logic super_t;
        logic cs;
        logic continuous_reload_select;
        logic [GP_W-1:0] gp;
        logic [GP_W-1:0] gp_rel;
        logic gp_run;
        logic [TMR_W-1:0] txt_cfg;
        logic [TMR_W-1:0] rxt_cfg;
        logic [CNT_W-1:0] txn_cfg;
        logic [CNT_W-1:0] rxn_cfg;
        logic load;
        gtm_port_t port;
        logic [31:0] sts;
        logic [31:0] msk;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic irq;
        logic gp_irq;
        logic rx_irq;
        logic tx_irq;
    } gtm_top_st_t;

    gtm_top_st_t r_reg;
    gtm_top_st_t r_next;
    gtm_chan_if #(.TW(TMR_W), .CW(CNT_W)) rx_if ();
    gtm_chan_if #(.TW(TMR_W), .CW(CNT_W)) tx_if ();
    logic [PRE_W-1:0] fine_len;
    logic access;
    logic done;
    logic gp_fire;
    logic [31:0] tmc_live;
    logic [31:0] rd_val;
    logic mapped;
    logic [31:0] set_bits;
    logic [31:0] clr_bits;

    // Fine unit length in core cycles for the selected port
    always_comb begin
        case (r_reg.port)
            PORT_TP_AUI: fine_len = PRE_W'(FINE_TP);
            PORT_SYM100: fine_len = PRE_W'(FINE_SYM);
            PORT_MII10: fine_len = PRE_W'(FINE_MII10);
            default: fine_len = PRE_W'(FINE_TP);
        endcase
    end

    // Live view of the control register: counters, not written values
    assign tmc_live = {r_reg.cs, tx_if.tim, tx_if.cnt, rx_if.tim, rx_if.cnt,
        r_reg.continuous_reload_select, r_reg.gp};
    assign access = i_psel && i_penable;
    assign done = access && r_reg.pready;

    // Read mux and address decode
    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h00000000;
        case (i_paddr)
            ADDR_STATUS: rd_val = r_reg.sts;
            ADDR_MASK: rd_val = r_reg.msk;
            ADDR_TMC: rd_val = tmc_live;
            ADDR_PORT: rd_val = {30'h00000000, r_reg.port};
            default: mapped = 1'b0;
        endcase
    end

    // Channel hookup; transmit unit is sixteen receive units
    assign rx_if.en = i_clk_en;
    assign rx_if.tick = r_reg.cs ? r_reg.fine : r_reg.coarse;
    assign rx_if.pkt = i_rx_pkt;
    assign rx_if.load = r_reg.load;
    assign rx_if.cfg_timer = r_reg.rxt_cfg;
    assign rx_if.cfg_count = r_reg.rxn_cfg;
    assign tx_if.en = i_clk_en;
    assign tx_if.tick = r_reg.cs ? r_reg.coarse : r_reg.super_t;
    assign tx_if.pkt = i_tx_pkt;
    assign tx_if.load = r_reg.load;
    assign tx_if.cfg_timer = r_reg.txt_cfg;
    assign tx_if.cfg_count = r_reg.txn_cfg;

    gtm_mit_chan #(.TW(TMR_W), .CW(CNT_W)) u_rx_chan (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .c(rx_if.chan)
    );

    gtm_mit_chan #(.TW(TMR_W), .CW(CNT_W)) u_tx_chan (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .c(tx_if.chan)
    );

    // Next state: prescaler, timer, bus slave, status
    always_comb begin
        r_next = r_reg;
        r_next.fine = 1'b0;
        r_next.coarse = 1'b0;
        r_next.super_t = 1'b0;
        r_next.load = 1'b0;
        gp_fire = 1'b0;
        set_bits = 32'h00000000;
        clr_bits = 32'h00000000;
        // Prescaler follows the port at each reload, so a port change shows a unit later
        if (r_reg.pre == '0) begin
            r_next.pre = fine_len - PRE_ONE;
            r_next.fine = 1'b1;
        end else begin
            r_next.pre = r_reg.pre - PRE_ONE;
        end
        // Coarse unit is sixteen fine units, super unit sixteen coarse units
        if (r_reg.fine) begin
            r_next.div = r_reg.div + DIV_ONE;
            r_next.coarse = (r_reg.div == DIV_LAST);
        end
        if (r_reg.coarse) begin
            r_next.txm = r_reg.txm + DIV_ONE;
            r_next.super_t = (r_reg.txm == TXM_LAST);
        end
        // General-purpose timer counts coarse iterations
        if (r_reg.gp_run && r_reg.coarse && !i_snooze) begin
            if (r_reg.gp <= GP_ONE) begin
                gp_fire = 1'b1;
                r_next.gp = r_reg.continuous_reload_select ? r_reg.gp_rel : '0;
                r_next.gp_run = r_reg.continuous_reload_select && (r_reg.gp_rel != '0);
            end else begin
                r_next.gp = r_reg.gp - GP_ONE;
            end
        end
        // APB: pready one cycle into the access phase, data captured then
        r_next.pready = access && !r_reg.pready;
        r_next.pslverr = access && !r_reg.pready && !mapped;
        if (access && !r_reg.pready) begin
            r_next.prdata = i_pwrite ? 32'h00000000 : rd_val;
        end
        if (done && i_pwrite) begin
            case (i_paddr)
                ADDR_MASK: r_next.msk = i_pwdata;
                ADDR_PORT: r_next.port = gtm_port_t'(i_pwdata[1:0]);
                ADDR_TMC: begin
                    r_next.cs = i_pwdata[TMC_CS_BIT];
                    r_next.txt_cfg = i_pwdata[TMC_TXT_LO +: TMR_W];
                    r_next.txn_cfg = i_pwdata[TMC_TXN_LO +: CNT_W];
                    r_next.rxt_cfg = i_pwdata[TMC_RXT_LO +: TMR_W];
                    r_next.rxn_cfg = i_pwdata[TMC_RXN_LO +: CNT_W];
                    r_next.continuous_reload_select = i_pwdata[TMC_CON_BIT];
                    r_next.gp = i_pwdata[TMC_GP_LO +: GP_W];
                    r_next.gp_rel = i_pwdata[TMC_GP_LO +: GP_W];
                    r_next.gp_run = i_pwdata[TMC_GP_LO +: GP_W] != '0;
                    r_next.load = 1'b1;
                end
                default: r_next.load = 1'b0;
            endcase
        end
        // Read clears only the bits it returned; a new event always wins
        if (done && !i_pwrite && i_paddr == ADDR_STATUS) begin
            clr_bits = r_reg.prdata;
        end
        set_bits[STS_GP_BIT] = gp_fire;
        set_bits[STS_RX_BIT] = rx_if.irq;
        set_bits[STS_TX_BIT] = tx_if.irq;
        r_next.sts = (r_reg.sts & ~clr_bits) | set_bits;
        r_next.irq = |(r_next.sts & r_next.msk);
        r_next.gp_irq = gp_fire;
        r_next.rx_irq = rx_if.irq;
        r_next.tx_irq = tx_if.irq;
    end

    // State register; enable low freezes everything, bus included
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            r_reg <= '{pre: '0, div: '0, txm: '0, fine: 1'b0, coarse: 1'b0, super_t: 1'b0,
                cs: TMC_RESET[TMC_CS_BIT], continuous_reload_select: TMC_RESET[TMC_CON_BIT],
                gp: TMC_RESET[TMC_GP_LO +: GP_W], gp_rel: TMC_RESET[TMC_GP_LO +: GP_W],
                gp_run: 1'b0, txt_cfg: TMC_RESET[TMC_TXT_LO +: TMR_W],
                rxt_cfg: TMC_RESET[TMC_RXT_LO +: TMR_W],
                txn_cfg: TMC_RESET[TMC_TXN_LO +: CNT_W],
                rxn_cfg: TMC_RESET[TMC_RXN_LO +: CNT_W], load: 1'b0, port: PORT_TP_AUI,
                sts: STS_RESET, msk: MSK_RESET, pready: 1'b0, prdata: 32'h00000000,
                pslverr: 1'b0, irq: 1'b0, gp_irq: 1'b0, rx_irq: 1'b0, tx_irq: 1'b0};
        end else if (i_clk_en) begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register
    assign o_pready = r_reg.pready;
    assign o_prdata = r_reg.prdata;
    assign o_pslverr = r_reg.pslverr;
    assign o_irq = r_reg.irq;
    assign o_gp_irq = r_reg.gp_irq;
    assign o_rx_irq = r_reg.rx_irq;
    assign o_tx_irq = r_reg.tx_irq;

    // Checking helper: enabled cycles between fine ticks, skipped after a port change
    logic [PRE_W:0] a_gap;
    logic [1:0] a_dirty;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            a_gap <= '0;
            a_dirty <= 2'h2;
        end else if (i_clk_en) begin
            a_gap <= r_reg.fine ? (PRE_W + 1)'(1) : a_gap + (PRE_W + 1)'(1);
            if (r_reg.port != r_next.port) begin
                a_dirty <= 2'h2;
            end else if (r_reg.fine && a_dirty != 2'h0) begin
                a_dirty <= a_dirty - 2'h1;
            end
        end
    end

    a_fine_period: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        r_reg.fine && a_dirty == 2'h0 |-> a_gap == {1'b0, fine_len})
        else $error("fine unit length does not match the port");
    a_gp_expiry: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        i_clk_en && r_reg.gp_run && r_reg.coarse && !i_snooze && r_reg.gp == GP_ONE
        |=> r_reg.sts[STS_GP_BIT] && o_gp_irq)
        else $error("timer expiry did not set status");
    a_gp_oneshot: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        i_clk_en && gp_fire && !r_reg.continuous_reload_select && !(done && i_pwrite) |=> !r_reg.gp_run && r_reg.gp == '0)
        else $error("one-shot timer kept running");
    a_gp_reload: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        i_clk_en && gp_fire && r_reg.continuous_reload_select && !(done && i_pwrite) |=> r_reg.gp == $past(r_reg.gp_rel))
        else $error("continuous timer did not reload");
    a_gp_snooze: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        i_snooze && !(done && i_pwrite) |=> r_reg.gp == $past(r_reg.gp))
        else $error("timer counted in snooze");
    a_read_live: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        i_clk_en && access && !r_reg.pready && !i_pwrite && i_paddr == ADDR_TMC
        |=> o_prdata == $past(tmc_live))
        else $error("read did not return live counts");
    a_load_cfg: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        i_clk_en && done && i_pwrite && i_paddr == ADDR_TMC
        |=> r_reg.load && r_reg.txn_cfg == $past(i_pwdata[TMC_TXN_LO +: CNT_W]))
        else $error("packet threshold not loaded");
    a_rx_unit: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        r_reg.cs |-> rx_if.tick == r_reg.fine && tx_if.tick == r_reg.coarse)
        else $error("cycle size select wrong");
endmodule
`default_nettype wire

/* File: test/gtm_timer_mit_tb.sv */
// Self-checking testbench of the timer and interrupt mitigation block
`timescale 1ns/10ps
`default_nettype none
module gp_timer_interrupt_mitigation_tb_top;
    import gtm_pkg::*;
    // Shortened fine units: coarse is 16 of them (tp 128, sym 64, mii10 256 cycles)
    localparam int SYM_COARSE = 64;
    logic i_core_clk;
    logic i_sys_rst;
    logic i_psel;
    logic i_penable;
    logic i_pwrite;
    logic [ADDR_W-1:0] i_paddr;
    logic [31:0] i_pwdata;
    logic o_pready;
    logic [31:0] o_prdata;
    logic o_pslverr;
    logic i_rx_pkt;
    logic i_tx_pkt;
    logic i_snooze;
    logic o_irq;
    logic o_gp_irq;
    logic o_rx_irq;
    logic o_tx_irq;
    int errors;
    int cmp_count;
    int cyc;
    logic [31:0] v;
    logic e;
    int n;

    // Small unit parameters keep every scenario to a few hundred cycles
    gtm_timer_mit #(.FINE_TP(8), .FINE_SYM(4), .FINE_MII10(16)) gtm_timer_mit_i (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
        .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_rx_pkt(i_rx_pkt),
        .i_tx_pkt(i_tx_pkt), .i_snooze(i_snooze), .o_irq(o_irq),
        .o_gp_irq(o_gp_irq), .o_rx_irq(o_rx_irq), .o_tx_irq(o_tx_irq)
    );

    // Clock at 200 MHz
    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    // Hang guard, well above the thousand or so cycles the scenarios take
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors = errors + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int k;
        @(posedge i_core_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_core_clk);
            k++;
        end while (o_pready !== 1'b1 && k < 50);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, v, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, v, e);
        chk(v, exp);
    endtask

    // One-cycle packet pulse; tx selects the transmit side
    task automatic pkt(input logic tx);
        @(posedge i_core_clk);
        i_tx_pkt <= tx;
        i_rx_pkt <= ~tx;
        @(posedge i_core_clk);
        i_tx_pkt <= 1'b0;
        i_rx_pkt <= 1'b0;
    endtask

    function automatic logic pick(input int w);
        return (w == 0) ? o_gp_irq : ((w == 1) ? o_rx_irq : o_tx_irq);
    endfunction

    // Edges until the chosen pulse is seen; maxc+1 when it never comes
    task automatic wait_irq(input int w, input int maxc, output int cnt);
        cnt = 0;
        do begin
            @(posedge i_core_clk);
            cnt++;
        end while (pick(w) !== 1'b1 && cnt < maxc);
        if (pick(w) !== 1'b1) begin
            cnt = maxc + 1;
        end
    endtask

    task automatic t_reset();
        rd_chk(ADDR_TMC, 32'hfffe0000);
        rd_chk(ADDR_STATUS, 32'h0);
        rd_chk(ADDR_MASK, 32'h0);
        rd_chk(ADDR_PORT, 32'h0);
        // Unmapped and unaligned places are refused
        apb(1'b1, 8'h30, 32'h1, v, e);
        chk(e, 1'b1);
        apb(1'b0, 8'h59, 32'h0, v, e);
        chk({v[30:0], e}, 32'h1);
        wr(ADDR_PORT, 32'h3);
        rd_chk(ADDR_PORT, 32'h3);
    endtask

    task automatic t_gp_oneshot();
        wr(ADDR_PORT, 32'h1);
        wr(ADDR_MASK, 32'h800);
        wr(ADDR_TMC, 32'h00000002);
        wait_irq(0, 200, n);
        chk(n >= SYM_COARSE - 1 && n <= 2 * SYM_COARSE + 2, 1);
        @(posedge i_core_clk);
        chk(o_irq, 1'b1);
        rd_chk(ADDR_TMC, 32'h00000000);
        rd_chk(ADDR_STATUS, 32'h800);
        rd_chk(ADDR_STATUS, 32'h0);
        chk(o_irq, 1'b0);
        // A stopped one-shot timer never fires again
        wait_irq(0, 200, n);
        chk(n, 201);
    endtask

    task automatic t_gp_cont();
        wr(ADDR_TMC, 32'h00010001);
        wait_irq(0, 200, n);
        wait_irq(0, 200, n);
        chk(n, SYM_COARSE);
        @(posedge i_core_clk);
        i_snooze <= 1'b1;
        wait_irq(0, 3 * SYM_COARSE, n);
        chk(n, 3 * SYM_COARSE + 1);
        @(posedge i_core_clk);
        i_snooze <= 1'b0;
        wait_irq(0, 80, n);
        chk(n <= SYM_COARSE + 2, 1);
        wr(ADDR_TMC, 32'h0);
        rd_chk(ADDR_STATUS, 32'h800);
        wr(ADDR_MASK, 32'h0);
    endtask

    task automatic t_rx_count();
        wr(ADDR_TMC, 32'h80060000);
        pkt(1'b0);
        wait_irq(1, 4, n);
        chk(n, 5);
        apb(1'b0, ADDR_TMC, 32'h0, v, e);
        chk(v[19:17], 3'd2);
        pkt(1'b0);
        pkt(1'b0);
        wait_irq(1, 4, n);
        chk(n, 2);
        rd_chk(ADDR_STATUS, 32'h40);
        apb(1'b0, ADDR_TMC, 32'h0, v, e);
        chk(v[19:17], 3'd3);
    endtask

    // Receive timer fires between lo and hi cycles after a packet
    task automatic t_rx_timer(input logic [31:0] port, input logic [31:0] ctrl,
                              input int lo, input int hi);
        wr(ADDR_PORT, port);
        wr(ADDR_TMC, ctrl);
        pkt(1'b0);
        wait_irq(1, hi + 5, n);
        chk(n >= lo && n <= hi, 1);
        rd_chk(ADDR_STATUS, 32'h40);
    endtask

    task automatic t_tx();
        wr(ADDR_PORT, 32'h1);
        wr(ADDR_TMC, 32'h92000000);
        pkt(1'b1);
        pkt(1'b1);
        wait_irq(2, 4, n);
        chk(n, 2);
        pkt(1'b1);
        wait_irq(2, 140, n);
        chk(n >= SYM_COARSE && n <= 2 * SYM_COARSE + 2, 1);
        rd_chk(ADDR_STATUS, 32'h1);
    endtask

    // Main sequence
    initial begin
        errors = 0;
        cmp_count = 0;
        cyc = 0;
        i_sys_rst = 1'b1;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = '0;
        i_pwdata = '0;
        i_rx_pkt = 1'b0;
        i_tx_pkt = 1'b0;
        i_snooze = 1'b0;
        repeat (4) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        t_reset();
        t_gp_oneshot();
        t_gp_cont();
        t_rx_count();
        t_rx_timer(32'h0, 32'h80200000, 8, 18);
        t_rx_timer(32'h1, 32'h00100000, 1, SYM_COARSE + 2);
        t_rx_timer(32'h2, 32'h80100000, 1, 18);
        t_tx();
        end_of_test();
    end
endmodule
`default_nettype wire
